// ==== inc/nvm_pkg.sv ====
// ****************************************************************
// Shared constants for the nonvolatile array controller.
// ****************************************************************
package nvm_pkg;
    // Bus widths and array geometry.
    localparam int AW = 16;
    localparam int DW = 32;
    localparam int ARRAY_BYTES = 256;
    localparam int BLOCK_BYTES = 128;
    localparam int IDX_W = 8;
    localparam int ADDR_LSB = 2;

    // Register byte addresses; each array byte takes one word.
    localparam logic [15:0] CTRL_ADDR = 16'h001C;
    localparam logic [15:0] OPT_ADDR = 16'h0020;
    localparam logic [15:0] CPU_ARRAY_BASE = 16'h0400;
    localparam logic [15:0] CPU_ARRAY_LAST = 16'h04FF;
    localparam logic [15:0] ARRAY_ADDR = CPU_ARRAY_BASE << ADDR_LSB;
    localparam logic [15:0] ARRAY_END = (CPU_ARRAY_LAST + 16'h0001) << ADDR_LSB;

    // Control register field positions and reset value.
    localparam int PGM_BIT = 0;
    localparam int LAT_BIT = 1;
    localparam int ER_LSB = 2;
    localparam int OSC_BIT = 4;
    localparam int CTRL_USED = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Options register field position.
    localparam int PRT_BIT = 0;

    // Erased byte value and bus responses.
    localparam logic [7:0] ERASED = 8'hFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Erase select field in its bit order.
    typedef enum logic [1:0] {ER_NONE, ER_BYTE, ER_BLOCK, ER_BULK} erase_e;

    // Address regions seen on the register bus.
    typedef enum logic [1:0] {REG_CTRL, REG_OPT, REG_ARRAY, REG_NONE} region_e;

    // Decodes a bus byte address into its region.
    function automatic region_e decode(input logic [AW-1:0] a);
        if (a[AW-1:ADDR_LSB] == CTRL_ADDR[AW-1:ADDR_LSB]) return REG_CTRL;
        if (a[AW-1:ADDR_LSB] == OPT_ADDR[AW-1:ADDR_LSB]) return REG_OPT;
        if (a >= ARRAY_ADDR && a < ARRAY_END) return REG_ARRAY;
        return REG_NONE;
    endfunction

    // Picks the array byte index out of a bus address.
    function automatic logic [IDX_W-1:0] arr_idx(input logic [AW-1:0] a);
        return a[ADDR_LSB +: IDX_W];
    endfunction
endpackage

// ==== inc/nvm_cell_if.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Link between the controller and the cell storage.
// ****************************************************************
interface nvm_cell_if (
    input wire logic aclk,
    input wire logic aresetn
);
    logic go;
    logic [1:0] blk_mask;
    logic byte_hit;
    logic byte_erase;
    logic [nvm_pkg::IDX_W-1:0] idx;
    logic [7:0] data;
    logic [nvm_pkg::IDX_W-1:0] rd_idx;
    logic [7:0] rd_data;
    logic opt_wr;
    logic opt_val;
    logic opt_cell;
    modport ctrl (input aclk, aresetn, rd_data, opt_cell,
                  output go, blk_mask, byte_hit, byte_erase, idx, data, rd_idx,
                  opt_wr, opt_val);
    modport cells (input aclk, aresetn, go, blk_mask, byte_hit, byte_erase, idx,
                   data, rd_idx, opt_wr, opt_val,
                   output rd_data, opt_cell);
endinterface

// ==== hw/nvm_cells.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Nonvolatile cells: the byte array and the protect option cell.
// ****************************************************************
module nvm_cells #(
    parameter int BYTES = nvm_pkg::ARRAY_BYTES
) (
    nvm_cell_if.cells bus
);
    // Cells keep their value across reset; they start erased.
    logic [7:0] mem_r [BYTES] = '{default: nvm_pkg::ERASED};
    logic opt_cell_r = 1'b1;

    // Erase sets whole blocks or one byte to ones; program only clears bits.
    always_ff @(posedge bus.aclk) begin
        for (int i = 0; i < BYTES; i++) begin
            if (bus.go && bus.blk_mask[i / nvm_pkg::BLOCK_BYTES]) begin
                mem_r[i] <= nvm_pkg::ERASED;
            end else if (bus.go && bus.byte_hit && bus.idx == nvm_pkg::IDX_W'(i)) begin
                mem_r[i] <= bus.byte_erase ? nvm_pkg::ERASED : (mem_r[i] & bus.data);
            end
        end
        if (bus.opt_wr) begin
            opt_cell_r <= bus.opt_val;
        end
    end

    // Read port and option cell towards the controller.
    assign bus.rd_data = mem_r[bus.rd_idx];
    assign bus.opt_cell = opt_cell_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge bus.aclk); endclocking
    default disable iff (!bus.aresetn);

    a_prog_clears_bits: assert property (
        bus.go && bus.byte_hit && !bus.byte_erase && bus.blk_mask == 2'b00
        |=> mem_r[$past(bus.idx)] == ($past(mem_r[bus.idx]) & $past(bus.data)))
        else $error("Programmed byte is not old value AND data.");
    a_block_two_erase: assert property (
        bus.go && bus.blk_mask == 2'b10
        |=> mem_r[nvm_pkg::BLOCK_BYTES] == nvm_pkg::ERASED
            && mem_r[BYTES-1] == nvm_pkg::ERASED)
        else $error("Block two erase left a byte programmed.");
    a_bulk_erase_all: assert property (
        bus.go && bus.blk_mask == 2'b11
        |=> mem_r[0] == nvm_pkg::ERASED && mem_r[BYTES-1] == nvm_pkg::ERASED)
        else $error("Bulk erase left a byte programmed.");
endmodule // nvm_cells

// ==== hw/eeprom_program_erase_control.sv ====
`timescale 1ns/1ps
// Function
// - 256-byte array at 0400-04FF, byte programming under register control.
// - Erased byte reads FF; programmed bits read zero.
// - Oscillator select bit picks RC clock; reset clears it.
// - Erase field 00 none, 01 byte, 10 block, 11 bulk; reset clears.
// - Block erase clears the 128-byte block holding latched address.
// - Bulk erase clears all 256 bytes with protect one, block one only with protect zero; refused if latched index low two bits are 00; byte erase clears one.
// - Latch enable zero forces erase field and power bit to zero.
// - Array write with latch on and power off captures address and data.
// - Power bit sets only with latch on; it gates pump power.
// - Option cells copy into working latch at reset; cells untouched.
// - Protect bit zero blocks program and erase of block two.
// - Protect zero written only with latch on; latch holds until reset.
// - Array reads FF with latch on, stored data otherwise.
// - During programming every array read returns FF.
// - Second program needs latch cleared and set again, else ignored.
module eeprom_program_erase_control (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [nvm_pkg::AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [nvm_pkg::DW-1:0] s_axi_wdata,
    input wire logic [nvm_pkg::DW/8-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [nvm_pkg::AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [nvm_pkg::DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic pump_on,
    output logic rc_clock_select
);
    // ****************************************************************
    // State
    // ****************************************************************
    logic aw_have_r, w_have_r, awready_r, wready_r, bvalid_r;
    logic [nvm_pkg::AW-1:0] aw_addr_r;
    logic [7:0] w_byte_r;
    logic w_lane_r;
    logic [1:0] bresp_r;
    logic arready_r, rvalid_r;
    logic [nvm_pkg::DW-1:0] rdata_r;
    logic [1:0] rresp_r;
    logic osc_r, lat_r, pgm_r;
    nvm_pkg::erase_e er_r;
    logic armed_r, cap_valid_r;
    logic [nvm_pkg::IDX_W-1:0] cap_idx_r;
    logic [7:0] cap_data_r;
    logic prot_r, load_r;
    logic go_r, byte_hit_r, byte_erase_r, opt_wr_r, opt_val_r;
    logic [1:0] blk_mask_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    nvm_cell_if cell_bus (.aclk(aclk), .aresetn(aresetn));

    // Storage for the array bytes and the protect option cell.
    nvm_cells #(.BYTES(nvm_pkg::ARRAY_BYTES)) u_cells (.bus(cell_bus));

    // ****************************************************************
    // Write channel handshake
    // ****************************************************************
    wire aw_take = s_axi_awvalid && awready_r;
    wire w_take = s_axi_wvalid && wready_r;
    wire do_wr = aw_have_r && w_have_r && !bvalid_r;
    wire aw_have_nxt = (aw_have_r && !do_wr) || aw_take;
    wire w_have_nxt = (w_have_r && !do_wr) || w_take;
    wire bvalid_nxt = do_wr || (bvalid_r && !s_axi_bready);

    // Decode of the held write; only the low byte lane carries data.
    nvm_pkg::region_e wr_region;
    assign wr_region = nvm_pkg::decode(aw_addr_r);
    wire wr_en = do_wr && w_lane_r;
    wire ctrl_wr = wr_en && wr_region == nvm_pkg::REG_CTRL;
    wire opt_wr = wr_en && wr_region == nvm_pkg::REG_OPT;
    wire arr_wr = wr_en && wr_region == nvm_pkg::REG_ARRAY;
    wire [nvm_pkg::IDX_W-1:0] wr_idx = nvm_pkg::arr_idx(aw_addr_r);
    wire [1:0] bresp_nxt = (wr_region == nvm_pkg::REG_NONE) ? nvm_pkg::RESP_SLVERR
                                                            : nvm_pkg::RESP_OKAY;

    // Address and data are held until both are in, then answered.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= nvm_pkg::RESP_OKAY;
        end else begin
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            awready_r <= !aw_have_nxt && !bvalid_nxt;
            wready_r <= !w_have_nxt && !bvalid_nxt;
            bvalid_r <= bvalid_nxt;
            if (do_wr) begin
                bresp_r <= bresp_nxt;
            end
        end
    end

    // Payload capture of the write channels.
    always_ff @(posedge aclk) begin
        if (aw_take) begin
            aw_addr_r <= s_axi_awaddr;
        end
        if (w_take) begin
            w_byte_r <= s_axi_wdata[7:0];
            w_lane_r <= s_axi_wstrb[0];
        end
    end

    // ****************************************************************
    // Control register next values
    // ****************************************************************
    // Clearing the latch drops the erase field and the power bit.
    wire wlat = w_byte_r[nvm_pkg::LAT_BIT];
    wire lat_nxt = ctrl_wr ? wlat : lat_r;
    wire osc_nxt = ctrl_wr ? w_byte_r[nvm_pkg::OSC_BIT] : osc_r;
    nvm_pkg::erase_e er_nxt;
    assign er_nxt = !ctrl_wr ? er_r :
                    wlat ? nvm_pkg::erase_e'(w_byte_r[nvm_pkg::ER_LSB +: 2])
                         : nvm_pkg::ER_NONE;
    wire pgm_nxt = ctrl_wr ? (wlat && lat_r && w_byte_r[nvm_pkg::PGM_BIT])
                           : pgm_r;
    wire pgm_rise = pgm_nxt && !pgm_r;
    wire lat_rise = lat_nxt && !lat_r;

    // One operation per latch session; a fresh latch rise re-arms it.
    wire armed_nxt = !lat_nxt ? 1'b0 : lat_rise ? 1'b1 : pgm_rise ? 1'b0 : armed_r;

    // Array writes are captured only while power is off.
    wire capture = arr_wr && lat_r && !pgm_r;
    wire cap_valid_nxt = !lat_nxt ? 1'b0 : (capture || cap_valid_r);
    wire commit = pgm_rise && armed_r && cap_valid_r;

    // ****************************************************************
    // Operation decode at the power-on edge
    // ****************************************************************
    // Byte and block operations on block two are refused unless the protect latch is one.
    wire cap_blk_two = cap_idx_r[nvm_pkg::IDX_W-1];
    wire blk_ok = !cap_blk_two || prot_r;
    wire bulk_addr_ok = |cap_idx_r[1:0];
    wire op_byte = er_nxt == nvm_pkg::ER_NONE || er_nxt == nvm_pkg::ER_BYTE;
    wire op_block = er_nxt == nvm_pkg::ER_BLOCK;
    wire op_bulk = er_nxt == nvm_pkg::ER_BULK;
    wire op_ok = op_bulk ? bulk_addr_ok : blk_ok;
    wire [1:0] block_one_hot = cap_blk_two ? 2'b10 : 2'b01;
    wire [1:0] bulk_mask = {prot_r, 1'b1};
    wire [1:0] blk_mask_nxt = op_block ? block_one_hot : op_bulk ? bulk_mask : 2'b00;

    // Control, capture and operation registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_r <= nvm_pkg::CTRL_RESET[nvm_pkg::OSC_BIT];
            er_r <= nvm_pkg::ER_NONE;
            lat_r <= nvm_pkg::CTRL_RESET[nvm_pkg::LAT_BIT];
            pgm_r <= nvm_pkg::CTRL_RESET[nvm_pkg::PGM_BIT];
            armed_r <= 1'b0;
            cap_valid_r <= 1'b0;
            go_r <= 1'b0;
        end else begin
            osc_r <= osc_nxt;
            er_r <= er_nxt;
            lat_r <= lat_nxt;
            pgm_r <= pgm_nxt;
            armed_r <= armed_nxt;
            cap_valid_r <= cap_valid_nxt;
            go_r <= commit && op_ok;
        end
    end

    // Captured target and the operation shape sent to the cells.
    always_ff @(posedge aclk) begin
        if (capture) begin
            cap_idx_r <= wr_idx;
            cap_data_r <= w_byte_r;
        end
        blk_mask_r <= blk_mask_nxt;
        byte_hit_r <= op_byte;
        byte_erase_r <= er_nxt == nvm_pkg::ER_BYTE;
    end

    // ****************************************************************
    // Protect option
    // ****************************************************************
    // The cell is written only with the latch on; the working copy is
    // loaded from the cell once, right after reset release.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prot_r <= 1'b0;
            load_r <= 1'b1;
            opt_wr_r <= 1'b0;
            opt_val_r <= 1'b1;
        end else begin
            load_r <= 1'b0;
            if (load_r) begin
                prot_r <= cell_bus.opt_cell;
            end
            opt_wr_r <= opt_wr && lat_r;
            opt_val_r <= w_byte_r[nvm_pkg::PRT_BIT];
        end
    end

    // Cell link wiring.
    assign cell_bus.go = go_r;
    assign cell_bus.blk_mask = blk_mask_r;
    assign cell_bus.byte_hit = byte_hit_r;
    assign cell_bus.byte_erase = byte_erase_r;
    assign cell_bus.idx = cap_idx_r;
    assign cell_bus.data = cap_data_r;
    assign cell_bus.opt_wr = opt_wr_r;
    assign cell_bus.opt_val = opt_val_r;
    assign cell_bus.rd_idx = nvm_pkg::arr_idx(s_axi_araddr);

    // ****************************************************************
    // Read channel
    // ****************************************************************
    wire ar_take = s_axi_arvalid && arready_r;
    wire rvalid_nxt = ar_take || (rvalid_r && !s_axi_rready);
    nvm_pkg::region_e rd_region;
    assign rd_region = nvm_pkg::decode(s_axi_araddr);

    // Read data per region; the array hides behind FF while latched.
    wire [7:0] ctrl_rd = {{(8 - nvm_pkg::CTRL_USED){1'b0}}, osc_r, er_r, lat_r, pgm_r};
    wire [7:0] arr_rd = lat_r ? nvm_pkg::ERASED : cell_bus.rd_data;
    wire [7:0] rd_byte = rd_region == nvm_pkg::REG_CTRL ? ctrl_rd :
                         rd_region == nvm_pkg::REG_OPT ? {7'h00, prot_r} :
                         rd_region == nvm_pkg::REG_ARRAY ? arr_rd : 8'h00;
    wire [1:0] rresp_nxt = (rd_region == nvm_pkg::REG_NONE) ? nvm_pkg::RESP_SLVERR
                                                           : nvm_pkg::RESP_OKAY;

    // Read answer registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= nvm_pkg::RESP_OKAY;
        end else begin
            arready_r <= !rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_take) begin
                rdata_r <= {{(nvm_pkg::DW - 8){1'b0}}, rd_byte};
                rresp_r <= rresp_nxt;
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign pump_on = pgm_r;
    assign rc_clock_select = osc_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_osc_select_write: assert property (
        ctrl_wr |=> rc_clock_select == $past(w_byte_r[nvm_pkg::OSC_BIT]))
        else $error("RC select does not follow the written bit.");
    a_erase_field_write: assert property (
        ctrl_wr && wlat |=> er_r == $past(w_byte_r[nvm_pkg::ER_LSB +: 2]))
        else $error("Erase field does not hold the written value.");
    a_latch_off_clears: assert property (
        !lat_r |-> er_r == nvm_pkg::ER_NONE && !pgm_r && !pump_on)
        else $error("Erase field or power set with latch off.");
    a_power_needs_latch: assert property (
        $rose(pgm_r) |-> $past(lat_r) && lat_r)
        else $error("Power bit rose without latch enable.");
    a_capture_target: assert property (
        capture |=> cap_idx_r == $past(wr_idx) && cap_valid_r)
        else $error("Array write with latch on was not captured.");
    a_no_capture_power: assert property (
        pgm_r && !capture |=> $stable(cap_idx_r) && $stable(cap_data_r))
        else $error("Target changed while power is on.");
    a_rearm_needed: assert property (
        pgm_rise && !armed_r |=> !go_r)
        else $error("Operation ran without a fresh latch.");
    a_block_two_guard: assert property (
        go_r |-> prot_r || (!blk_mask_r[1] && !(byte_hit_r && cap_idx_r[nvm_pkg::IDX_W-1])))
        else $error("Block two changed while protected.");
    a_latched_read_ff: assert property (
        ar_take && rd_region == nvm_pkg::REG_ARRAY && lat_r
        |=> s_axi_rvalid && s_axi_rdata[7:0] == nvm_pkg::ERASED)
        else $error("Array read under latch did not return FF.");
    a_ctrl_upper_zero: assert property (
        ar_take && rd_region == nvm_pkg::REG_CTRL
        |=> s_axi_rdata[nvm_pkg::DW-1:nvm_pkg::CTRL_USED] == '0)
        else $error("Unused control bits read as one.");
    a_protect_persists: assert property (
        !load_r |=> $stable(prot_r))
        else $error("Protect latch changed outside reset load.");
    a_write_answer: assert property (
        do_wr |=> s_axi_bvalid ##0 s_axi_bvalid [*1])
        else $error("Write answer missing one cycle after both channels.");

    c_program_byte: cover property (go_r && byte_hit_r && !byte_erase_r);
    c_bulk_erase: cover property (go_r && blk_mask_r == 2'b11);
    c_refused_rearm: cover property (pgm_rise && !armed_r);
    c_latched_read: cover property (ar_take && rd_region == nvm_pkg::REG_ARRAY && lat_r);
endmodule // eeprom_program_erase_control

// ==== tb/eeprom_program_erase_control_test.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module eeprom_program_erase_control_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0000;
    logic [15:0] s_axi_araddr = 16'h0000;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [31:0] s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic pump_on, rc_clock_select;
    int errors = 0;
    int checks_done = 0;
    localparam logic [15:0] CT = nvm_pkg::CTRL_ADDR;
    localparam logic [15:0] OP = nvm_pkg::OPT_ADDR;
    localparam logic [15:0] BAD = 16'h0FF0;
    localparam logic [1:0] OK = nvm_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = nvm_pkg::RESP_SLVERR;
    localparam logic [7:0] FF = nvm_pkg::ERASED;
    // Cycles the bench waits for the RC oscillator to settle; a plain default.
    localparam int RC_SETTLE = 8;
    // ****************************************************************
    // Clock, device and bus tasks.
    // ****************************************************************
    // The clock toggles every half period of 4 ns.
    always #4 aclk = ~aclk;
    eeprom_program_erase_control dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pump_on, .rc_clock_select);
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [15:0] ad(input int i);
        return nvm_pkg::ARRAY_ADDR + 16'(i * 4);
    endfunction
    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    // Write one byte; address and data stay up until each is taken.
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (n > 50) begin
                errors++;
                $display("Error at %0t: write answer timed out", $time);
                print_verdict;
            end
        end while (s_axi_bvalid !== 1'b1);
        `CHK(s_axi_bresp, er)
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (n > 50) begin
                errors++;
                $display("Error at %0t: read answer timed out", $time);
                print_verdict;
            end
        end while (s_axi_rvalid !== 1'b1);
        `CHK(s_axi_rdata, {24'h000000, d})
        `CHK(s_axi_rresp, er)
    endtask
    // One latched operation with mode bits m on byte i.
    task automatic op(input logic [7:0] m, input int i, input logic [7:0] d);
        wr(CT, 8'h02 | m, OK);
        wr(ad(i), d, OK);
        rd(ad(i), FF, OK);
        wr(CT, 8'h03 | m, OK);
        `CHK(pump_on, 1'b1)
        rd(ad(i), FF, OK);
        wr(CT, 8'h00, OK);
        `CHK(pump_on, 1'b0)
    endtask
    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_reset;
        rd(CT, nvm_pkg::CTRL_RESET, OK);
        `CHK(rc_clock_select, 1'b0)
        rd(ad(0), FF, OK);
        rd(ad(255), FF, OK);
        rd(BAD, 8'h00, ERR);
        wr(BAD, 8'h00, ERR);
        $display("reset test done");
    endtask
    task automatic t_ctrl;
        wr(CT, 8'hFF, OK);
        rd(CT, 8'h1E, OK);
        `CHK(rc_clock_select, 1'b1)
        repeat (RC_SETTLE) @(posedge aclk);
        wr(CT, 8'h1D, OK);
        rd(CT, 8'h10, OK);
        wr(CT, 8'h00, OK);
        $display("control test done");
    endtask
    task automatic t_program;
        op(8'h00, 5, 8'h5A);
        rd(ad(5), 8'h5A, OK);
        op(8'h00, 128, 8'h00);
        rd(ad(128), 8'h00, OK);
        wr(CT, 8'h02, OK);
        wr(ad(6), 8'hF0, OK);
        wr(CT, 8'h03, OK);
        wr(CT, 8'h02, OK);
        wr(ad(7), 8'h0F, OK);
        wr(CT, 8'h03, OK);
        wr(CT, 8'h00, OK);
        rd(ad(6), 8'hF0, OK);
        rd(ad(7), FF, OK);
        $display("program test done");
    endtask
    task automatic t_erase;
        op(8'h04, 5, 8'h00);
        rd(ad(5), FF, OK);
        rd(ad(6), 8'hF0, OK);
        op(8'h08, 6, 8'h00);
        rd(ad(6), FF, OK);
        rd(ad(128), 8'h00, OK);
        op(8'h08, 200, 8'h00);
        rd(ad(128), FF, OK);
        op(8'h00, 128, 8'h00);
        rd(ad(128), 8'h00, OK);
        $display("erase test done");
    endtask
    task automatic t_protect;
        wr(OP, 8'h00, OK);
        do_reset;
        rd(OP, 8'h01, OK);
        wr(CT, 8'h02, OK);
        wr(OP, 8'h00, OK);
        wr(CT, 8'h00, OK);
        rd(OP, 8'h01, OK);
        do_reset;
        rd(OP, 8'h00, OK);
        op(8'h00, 129, 8'h00);
        rd(ad(129), FF, OK);
        op(8'h00, 2, 8'h00);
        op(8'h0C, 1, 8'h00);
        rd(ad(2), FF, OK);
        rd(ad(128), 8'h00, OK);
        wr(CT, 8'h02, OK);
        wr(OP, 8'h01, OK);
        wr(CT, 8'h00, OK);
        do_reset;
        op(8'h0C, 4, 8'h00);
        rd(ad(128), 8'h00, OK);
        op(8'h0C, 1, 8'h00);
        rd(ad(128), FF, OK);
        $display("protect test done");
    endtask
    // Main sequence.
    initial begin
        do_reset;
        t_reset;
        t_ctrl;
        t_program;
        t_erase;
        t_protect;
        print_verdict;
    end
endmodule // eeprom_program_erase_control_test
